// ===== dac_bank_regs.vh
// Register offsets, field positions and reset values for the DAC gain and lock register bank
`ifndef DAC_BANK_REGS_VH
`define DAC_BANK_REGS_VH

// ****************************************
// Register addresses (5-bit serial address)
// ****************************************
`define ADDR_VOL_CODE_BASE   5'h00
`define ADDR_VOL_PWRDN       5'h09
`define ADDR_VOL_GAIN        5'h0a
`define ADDR_LOCK_STATUS     5'h0b
`define ADDR_NV_GAIN         5'h1a

// ****************************************
// Field positions
// ****************************************
`define GAIN_FIELD_LSB       8
`define PWRDN_FIELD_W        2

// ****************************************
// Reset values
// ****************************************
`define NV_LOCK_DEFAULT      2'h0
`define PWRDN_NORMAL         2'h0

`endif

// ===== dac_gain_lock_status_regs.v
// Gain, lock status and ladder control register bank of a multi-channel voltage DAC
`timescale 1ns/10ps
`include "dac_bank_regs.vh"

// Operation
// - One gain bit per channel, 1 is 2x
// - Unimplemented gain register bits read zero
// - Lock pair encodes four lock levels
// - Lock status loads programmed value after reset
// - Volatile code selects ladder wiper position
// - Highest wiper position is 2^n minus one
// - Power-down disconnects ladder from reference
// - Up to eight channels, absent ones unimplemented
// - Reset loads volatile state from nonvolatile
// - Volatile gain changes by reset or write
module dac_gain_lock_status_regs #(
  parameter CHANNELS = 8,
  parameter RES_BITS = 12
) (
  // Clock and reset
  input  wire                         clk,
  input  wire                         rstn,
  // Register access from the serial command engine
  input  wire                         wr_en,
  input  wire                         rd_en,
  input  wire [4:0]                   addr,
  input  wire [15:0]                  wdata,
  output reg  [15:0]                  rdata,
  output reg                          rvalid,
  // Nonvolatile state presented by the memory
  input  wire [2*CHANNELS-1:0]        lock_cfg_pair,
  input  wire [CHANNELS-1:0]          nv_gain_in,
  input  wire [CHANNELS*RES_BITS-1:0] nv_code_in,
  input  wire [2*CHANNELS-1:0]        nv_pwrdn_in,
  // Analog controls
  output reg  [CHANNELS-1:0]          out_gain_sel,
  output wire [CHANNELS*RES_BITS-1:0] wiper_pos,
  output wire [CHANNELS-1:0]          ladder_ref_node
);

  // ****************************************
  // Register state
  // ****************************************
  reg  [CHANNELS-1:0]   nv_gain_reg;
  reg  [CHANNELS-1:0]   vol_gain_reg;
  reg  [RES_BITS-1:0]   code_reg  [0:CHANNELS-1];
  reg  [1:0]            pwrdn_reg [0:CHANNELS-1];
  reg  [2*CHANNELS-1:0] lock_state_mirror;
  reg                   load_pending_reg;
  reg  [15:0]           rdata_next;
  integer               i;
  integer               j;
  integer               p;
  wire [CHANNELS-1:0]   code_hit;

  // Widen a channel field into the gain byte, absent channels stay zero
  function [15:0] gain_word;
    input [CHANNELS-1:0] g;
    reg   [7:0]          b;
    begin
      b = 8'h00;
      b[CHANNELS-1:0] = g;
      gain_word = {b, 8'h00};
    end
  endfunction

  // Address of one channel's code register, kept in one place so write and read decode agree
  function [4:0] code_addr;
    input integer ch;
    begin
      code_addr = `ADDR_VOL_CODE_BASE + ch[4:0];
    end
  endfunction

  // ****************************************
  // Address decode
  // ****************************************
  // One match line per implemented channel, so an absent channel can never be addressed
  genvar m;
  generate
    for (m = 0; m < CHANNELS; m = m + 1) begin : g_hit
      assign code_hit[m] = (addr == code_addr(m));
    end
  endgenerate

  // ****************************************
  // Recall and write path
  // ****************************************
  // Recall runs on the first clock after release, which keeps every reset branch constant-only
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      load_pending_reg <= 1'b1;
    end else begin
      load_pending_reg <= 1'b0;
    end
  end

  // Gain registers; the lock status address has no write branch anywhere, so writes there fall through
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nv_gain_reg  <= {CHANNELS{1'b0}};
      vol_gain_reg <= {CHANNELS{1'b0}};
    end else if (load_pending_reg) begin
      nv_gain_reg  <= nv_gain_in;
      vol_gain_reg <= nv_gain_in;
    end else if (wr_en && (addr == `ADDR_NV_GAIN)) begin
      nv_gain_reg  <= wdata[`GAIN_FIELD_LSB +: CHANNELS];
    end else if (wr_en && (addr == `ADDR_VOL_GAIN)) begin
      vol_gain_reg <= wdata[`GAIN_FIELD_LSB +: CHANNELS];
    end
  end

  // Output codes; a write in the recall cycle is dropped so the recalled value always lands
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < CHANNELS; i = i + 1) begin
        code_reg[i] <= {RES_BITS{1'b0}};
      end
    end else if (load_pending_reg) begin
      for (i = 0; i < CHANNELS; i = i + 1) begin
        code_reg[i] <= nv_code_in[i*RES_BITS +: RES_BITS];
      end
    end else if (wr_en) begin
      for (i = 0; i < CHANNELS; i = i + 1) begin
        if (code_hit[i]) begin
          code_reg[i] <= wdata[RES_BITS-1:0];
        end
      end
    end
  end

  // Power-down fields, one pair per channel from bit 0
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (p = 0; p < CHANNELS; p = p + 1) begin
        pwrdn_reg[p] <= `PWRDN_NORMAL;
      end
    end else if (load_pending_reg) begin
      for (p = 0; p < CHANNELS; p = p + 1) begin
        pwrdn_reg[p] <= nv_pwrdn_in[2*p +: 2];
      end
    end else if (wr_en && (addr == `ADDR_VOL_PWRDN)) begin
      for (p = 0; p < CHANNELS; p = p + 1) begin
        pwrdn_reg[p] <= wdata[2*p +: 2];
      end
    end
  end

  // ****************************************
  // Lock status mirror
  // ****************************************
  // Lock mirror follows the nonvolatile pairs every cycle; reset value is the shipped unlocked state
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lock_state_mirror <= {2*CHANNELS{1'b0}};
    end else begin
      lock_state_mirror <= lock_cfg_pair;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // Read decode; unmapped addresses and unimplemented bits fall out as zero
  always @* begin
    rdata_next = 16'h0000;
    case (addr)
      `ADDR_NV_GAIN:     rdata_next = gain_word(nv_gain_reg);
      `ADDR_VOL_GAIN:    rdata_next = gain_word(vol_gain_reg);
      `ADDR_LOCK_STATUS: rdata_next[2*CHANNELS-1:0] = lock_state_mirror;
      `ADDR_VOL_PWRDN: begin
        for (j = 0; j < CHANNELS; j = j + 1) begin
          rdata_next[2*j +: 2] = pwrdn_reg[j];
        end
      end
      default: begin
        for (j = 0; j < CHANNELS; j = j + 1) begin
          if (code_hit[j]) begin
            rdata_next[RES_BITS-1:0] = code_reg[j];
          end
        end
      end
    endcase
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  // Read answer one cycle after rd_en; rdata holds until the next read so a slow host can still take it
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata  <= 16'h0000;
      rvalid <= 1'b0;
    end else begin
      rvalid <= rd_en;
      if (rd_en) begin
        rdata <= rdata_next;
      end
    end
  end

  // Gain pins follow the volatile gain one clock later, straight from a flip-flop
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_gain_sel <= {CHANNELS{1'b0}};
    end else begin
      out_gain_sel <= vol_gain_reg;
    end
  end

  // ****************************************
  // Per-channel ladder decode
  // ****************************************
  // The analog side sees a new code one clock after the register takes it
  genvar c;
  generate
    for (c = 0; c < CHANNELS; c = c + 1) begin : g_ch
      ladder_decode #(
        .RES_BITS (RES_BITS)
      ) u_ladder (
        .clk         (clk),
        .rstn        (rstn),
        .code        (code_reg[c]),
        .pwrdn       (pwrdn_reg[c]),
        .wiper_pos   (wiper_pos[c*RES_BITS +: RES_BITS]),
        .ref_connect (ladder_ref_node[c])
      );
    end
  endgenerate

endmodule

// ===== dac_gain_lock_status_regs_bench.sv
// Self-checking bench for the gain, lock and ladder register bank
`timescale 1ns/10ps
module dac_gain_lock_status_regs_bench;
  logic        clk = 1'b0, rstn = 1'b0, wr_en, rd_en, rvalid;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata, d, g, lock_cfg_pair = 16'h0000, nv_pwrdn_in;
  logic [7:0]  nv_gain_in, out_gain_sel, ladder_ref_node;
  logic [95:0] nv_code_in, wiper_pos;
  logic [11:0] c;
  int          seed = 93, fails = 0, checks = 0;
  always #25 clk = ~clk;
  dac_gain_lock_status_regs u_dac_gain_lock_status_regs (.clk(clk), .rstn(rstn), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid), .lock_cfg_pair(lock_cfg_pair),
    .nv_gain_in(nv_gain_in), .nv_code_in(nv_code_in), .nv_pwrdn_in(nv_pwrdn_in), .out_gain_sel(out_gain_sel),
    .wiper_pos(wiper_pos), .ladder_ref_node(ladder_ref_node));
  host_model u_host_model (.clk(clk), .rvalid(rvalid), .rdata(rdata), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata));
  // Compare and count; an unknown never matches
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rdc(input logic [4:0] a, input logic [15:0] e);
    u_host_model.rd(a, d);
    chk("read", d, e);
  endtask
  task automatic complete_run;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Recall after reset, then codes at full and zero scale, locks and modes in turn
  initial begin
    nv_gain_in = $random(seed);
    nv_pwrdn_in = $random(seed);
    nv_code_in = {$random(seed), $random(seed), $random(seed)};
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    rdc(5'h0a, {nv_gain_in, 8'h00});
    rdc(5'h0b, 16'h0000);
    rdc(5'h1f, 16'h0000);
    for (int k = 0; k < 8; k++) begin
      c = k == 0 ? 12'hfff : k == 1 ? 12'h000 : 12'($random(seed));
      g = $random(seed);
      lock_cfg_pair = {8{k[1:0]}};
      u_host_model.wr(k[4:0], {4'h0, c});
      u_host_model.wr(5'h0a, g);
      u_host_model.wr(5'h09, {8{k[2:1]}});
      u_host_model.wr_rd(5'h0b, ~lock_cfg_pair, d);
      chk("lockwr", d, lock_cfg_pair);
      u_host_model.wr(5'h1a, ~g);
      chk("wiper", wiper_pos[12*k+:12], c);
      chk("gain", out_gain_sel, g[15:8]);
      chk("ladder", ladder_ref_node, k[2:1] == 2'h0 ? 8'hff : 8'h00);
      rdc(5'h0b, lock_cfg_pair);
      rdc(5'h1a, {~g[15:8], 8'h00});
      rdc(5'h0a, {g[15:8], 8'h00});
    end
    // Second power-on mid-run: fresh gain and code recall values, lock pairs left programmed at all ones
    nv_gain_in = $random(seed);
    nv_code_in = {$random(seed), $random(seed), $random(seed)};
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    chk("recall", wiper_pos[11:0], nv_code_in[11:0]);
    rdc(5'h0a, {nv_gain_in, 8'h00});
    rdc(5'h0b, lock_cfg_pair);
    complete_run;
  end
endmodule

// ===== dac_regs_asserts.sv
// Concurrent checks of the gain, lock and ladder register bank
`timescale 1ns/10ps
module dac_regs_asserts #(parameter CH = 8, parameter RB = 12) (
  // Access and controls
  input wire             clk,
  input wire             rstn,
  input wire             wr_en,
  input wire             rd_en,
  input wire [4:0]       addr,
  input wire [15:0]      wdata,
  input wire [15:0]      rdata,
  input wire             rvalid,
  input wire [2*CH-1:0]  lock_cfg_pair,
  input wire [CH-1:0]    nv_gain_in,
  input wire [CH*RB-1:0] nv_code_in,
  input wire [CH-1:0]    out_gain_sel,
  input wire [CH*RB-1:0] wiper_pos,
  input wire [CH-1:0]    ladder_ref_node
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // A write reaches the outputs two edges after it is taken
  AST_GAIN: assert property (wr_en && addr == 5'h0a |-> ##2 out_gain_sel == CH'($past(wdata, 2) >> 8))
    else $error("gain");
  AST_PAD: assert property (rd_en && addr == 5'h1a |=> rdata[7:0] == 8'h00)
    else $error("pad");
  AST_LOCK: assert property (rd_en && addr == 5'h0b |=> rdata[2*CH-1:0] == $past(lock_cfg_pair, 2))
    else $error("lock");
  AST_CODE: assert property (wr_en && addr < CH |-> ##2 RB'(wiper_pos >> RB * $past(addr, 2)) == RB'($past(wdata, 2)))
    else $error("code");
  AST_LADDER: assert property (wr_en && addr == 5'h09 |-> ##2 ladder_ref_node[0] == ~|$past(wdata[1:0], 2))
    else $error("ladder");
  // Recall reaches the gain pins three edges after the last edge seen in reset
  AST_HOLD: assert property ($changed(out_gain_sel) |-> $past(wr_en && addr == 5'h0a, 2) || $past(!rstn, 3))
    else $error("hold");
  AST_RECALL: assert property ($rose(rstn) |-> ##2 out_gain_sel == $past(nv_gain_in, 2))
    else $error("recall gain");
  AST_RECALLC: assert property ($rose(rstn) |-> ##2 wiper_pos == $past(nv_code_in, 2))
    else $error("recall code");
  AST_UNMAP: assert property (rd_en && addr == 5'h1f |=> rvalid && rdata == 16'h0000)
    else $error("unmapped");
  AST_QUIET: assert property (!rd_en |=> !rvalid)
    else $error("rvalid");
endmodule
bind dac_gain_lock_status_regs dac_regs_asserts #(.CH(CHANNELS), .RB(RES_BITS)) u_dac_regs_asserts (.clk(clk),
  .rstn(rstn), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid),
  .lock_cfg_pair(lock_cfg_pair), .nv_gain_in(nv_gain_in), .nv_code_in(nv_code_in),
  .out_gain_sel(out_gain_sel), .wiper_pos(wiper_pos),
  .ladder_ref_node(ladder_ref_node));

// ===== host_model.sv
// Host model issuing one-cycle register writes and reads
`timescale 1ns/10ps
module host_model (
  // Register access
  input  wire         clk,
  input  wire         rvalid,
  input  wire  [15:0] rdata,
  output logic        wr_en = 1'b0,
  output logic        rd_en = 1'b0,
  output logic [4:0]  addr = 5'h00,
  output logic [15:0] wdata = 16'h0000
);
  // Data is inverted on release so a stale word never looks valid
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(negedge clk) {wr_en, addr, wdata} = {1'b1, a, v};
    @(negedge clk) {wr_en, wdata} = {1'b0, ~v};
  endtask
  // The answer stands for exactly one cycle after the request edge
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(negedge clk) {rd_en, addr} = {1'b1, a};
    @(negedge clk) rd_en = 1'b0;
    v = rvalid === 1'b1 ? rdata : 16'hxxxx;
  endtask
  // Write then read the same address on the next edge, so a write that landed would show at once
  task automatic wr_rd(input logic [4:0] a, input logic [15:0] v, output logic [15:0] r);
    @(negedge clk) {wr_en, addr, wdata} = {1'b1, a, v};
    @(negedge clk) {wr_en, rd_en, wdata} = {1'b0, 1'b1, ~v};
    @(negedge clk) rd_en = 1'b0;
    r = rvalid === 1'b1 ? rdata : 16'hxxxx;
  endtask
endmodule

// ===== ladder_decode.v
// One channel's wiper position decode and ladder reference switch
`timescale 1ns/10ps
`include "dac_bank_regs.vh"
module ladder_decode #(
  parameter RES_BITS = 12
) (
  // Clock and reset
  input  wire                clk,
  input  wire                rstn,
  // Channel controls
  input  wire [RES_BITS-1:0] code,
  input  wire [1:0]          pwrdn,
  // Ladder controls
  output reg  [RES_BITS-1:0] wiper_pos,
  output reg                 ref_connect
);

  // Code maps straight onto a tap; the top tap 2^n-1 still leaves one element to the reference node
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wiper_pos   <= {RES_BITS{1'b0}};
      ref_connect <= 1'b0;
    end else begin
      wiper_pos   <= code;
      ref_connect <= (pwrdn == `PWRDN_NORMAL);
    end
  end

endmodule
